/* include/aspm_pkg.sv */
// Purpose: shared constants and types for the converter serial/power control
// Assumes: system clock 100 MHz, serial clock sampled as a plain input
// Notes: edge counts are serial-clock falling edges since frame start
`default_nettype none
package aspm_pkg;
  localparam int          ASPM_WORD_BITS    = 16;
  localparam int          ASPM_LEAD_ZEROS   = 2;
  localparam int          ASPM_RES_BITS_12  = 12;
  localparam logic [4:0]  ASPM_CNT_GLITCH   = 5'h02;
  localparam logic [4:0]  ASPM_CNT_AWAKE    = 5'h0A;
  localparam logic [4:0]  ASPM_CNT_FULL     = 5'h10;
  localparam logic [4:0]  ASPM_CNT_ZERO     = 5'h00;
  localparam logic [15:0] ASPM_WORD_ZERO    = 16'h0000;
  localparam logic [1:0]  ASPM_SYNC_ZERO    = 2'h0;
  localparam logic [1:0]  ASPM_SYNC_IDLE    = 2'h3;

  typedef enum logic [1:0] {
    ASPM_NORMAL,
    ASPM_PARTIAL,
    ASPM_FULL
  } aspm_mode_e;
endpackage : aspm_pkg
`default_nettype wire

/* core/aspm_sync.sv */
// Purpose: two-flop synchroniser for the serial pins
// Assumes: inputs asynchronous to clock_in
// Notes: first stage read only by the second
`default_nettype none
module aspm_sync
  import aspm_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } aspm_sync_s;

  aspm_sync_s state;
  aspm_sync_s next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '{stage1: {WIDTH{1'b1}}, stage2: {WIDTH{1'b1}}};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;
endmodule // aspm_sync
`default_nettype wire

/* core/aspm_ctrl.sv */
// Purpose: frame-select serial readout and power-mode control of the converter
// Assumes: frame select and serial clock come from the host, sampled here
// Notes: result sampled from conv_result_in at the frame-select fall
// Functional notes
// - 16-bit word, two leading zero bits
// - trailing zeros pad to sixteen positions
// - frame-select rise edge count picks mode
// - sample and start at frame-select fall
// - rise in 10..15 stays powered, aborts
// - rise in 2..9 enters partial power-down
// - rise before second edge stays normal
// - dummy frame past 10 wakes device
// - partial then early rise gives full
// - drive at fall, release at 16th edge
`default_nettype none
module aspm_ctrl
  import aspm_pkg::*;
#(
  parameter int RES_BITS = ASPM_RES_BITS_12
) (
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  input  wire logic                frame_sel_n_in,
  input  wire logic                serial_clk_in,
  input  wire logic [RES_BITS-1:0] conv_result_in,
  output var  logic                serial_result_out,
  output var  logic                serial_result_oe_out,
  output var  logic [1:0]          power_mode_out,
  output var  logic                sample_out
);
  typedef struct packed {
    logic                frame_q;
    logic                sclk_q;
    logic                active;
    logic [4:0]          edges;
    logic [15:0]         shift;
    logic                sdo;
    logic                oe;
    aspm_mode_e          mode;
    logic                sample;
  } aspm_ctrl_s;

  aspm_ctrl_s state;
  aspm_ctrl_s next_state;
  logic [1:0] pins_sync;
  logic       frame_n;
  logic       sclk;
  logic       frame_fall;
  logic       frame_rise;
  logic       sclk_fall;

  localparam logic [4:0] TRAIL_FROM = 5'(ASPM_LEAD_ZEROS + RES_BITS - 1);

  aspm_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in ({frame_sel_n_in, serial_clk_in}),
    .sync_out (pins_sync)
  );

  assign frame_n    = pins_sync[1];
  assign sclk       = pins_sync[0];
  assign frame_fall = state.frame_q && !frame_n;
  assign frame_rise = !state.frame_q && frame_n;
  assign sclk_fall  = state.sclk_q && !sclk;

  always_comb begin
    next_state         = state;
    next_state.frame_q = frame_n;
    next_state.sclk_q  = sclk;
    next_state.sample  = 1'b0;
    if (frame_fall) begin
      next_state.sample = 1'b1;
      next_state.active = 1'b1;
      next_state.edges  = ASPM_CNT_ZERO;
      // zeros, result, zero pad
      // bit 15 already on the pin, queue the rest
      next_state.shift  = ASPM_WORD_ZERO
                        | (16'(conv_result_in)
                           << (ASPM_WORD_BITS - ASPM_LEAD_ZEROS - RES_BITS + 1));
      next_state.oe     = 1'b1;
      next_state.sdo    = 1'b0;
    end else if (frame_n) begin
      next_state.edges  = ASPM_CNT_ZERO;
      next_state.active = 1'b0;
      next_state.oe     = 1'b0;
      if (frame_rise && state.active) begin
        if (state.edges >= ASPM_CNT_AWAKE) begin
          next_state.mode = ASPM_NORMAL;
        end else if (state.mode != ASPM_NORMAL) begin
          next_state.mode = ASPM_FULL;
        end else if (state.edges >= ASPM_CNT_GLITCH) begin
          next_state.mode = ASPM_PARTIAL;
        end
      end
    end else if (state.active && sclk_fall) begin
      next_state.sdo   = state.shift[15];
      next_state.shift = {state.shift[14:0], 1'b0};
      next_state.edges = state.edges + 5'h01;
      if (state.edges + 5'h01 == ASPM_CNT_FULL) begin
        next_state.oe     = 1'b0;
        next_state.active = 1'b0;
        next_state.mode   = ASPM_NORMAL;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '{frame_q: 1'b1, sclk_q: 1'b1, active: 1'b0, edges: ASPM_CNT_ZERO,
                 shift: ASPM_WORD_ZERO, sdo: 1'b0, oe: 1'b0, mode: ASPM_NORMAL,
                 sample: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign serial_result_out    = state.sdo;
  assign serial_result_oe_out = state.oe;
  assign power_mode_out       = state.mode;
  assign sample_out           = state.sample;

  edge_idle_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state.frame_q && frame_n |=> state.edges == ASPM_CNT_ZERO)
    else $error("edge counter not cleared while frame select high");

  drive_start_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_fall |=> serial_result_oe_out && sample_out)
    else $error("output not driven after frame select fall");

  release_full_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state.active && !frame_n && sclk_fall && state.edges == 5'h0F
    |=> !serial_result_oe_out)
    else $error("output not released at sixteenth edge");

  lead_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state.active && !frame_n && sclk_fall && state.edges == ASPM_CNT_ZERO
    |=> !serial_result_out)
    else $error("leading bit not zero");

  partial_entry_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_rise && state.active && state.mode == ASPM_NORMAL
    && state.edges >= 5'h02 && state.edges < 5'h0A
    |=> power_mode_out == ASPM_PARTIAL && !serial_result_oe_out)
    else $error("partial power-down not entered");

  glitch_keep_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_rise && state.active && state.mode == ASPM_NORMAL && state.edges < 5'h02
    |=> power_mode_out == ASPM_NORMAL)
    else $error("glitch caused power-down");

  late_rise_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_rise && state.active && state.edges >= 5'h0A
    |=> power_mode_out == ASPM_NORMAL && !serial_result_oe_out)
    else $error("late rise did not keep device powered");

  full_entry_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_rise && state.active && state.mode == ASPM_PARTIAL && state.edges < 5'h0A
    |=> power_mode_out == ASPM_FULL)
    else $error("full power-down not entered");

  first_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_fall |=> !serial_result_out)
    else $error("first bit not zero");

  trail_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state.active && !frame_n && sclk_fall && state.edges >= TRAIL_FROM
    |=> !serial_result_out)
    else $error("trailing bit not zero");

  shift_msb_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state.active && !frame_n && sclk_fall
    |=> serial_result_out == $past(state.shift[15]))
    else $error("serial bit not taken from top of shift word");

  sample_only_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !frame_fall |=> !sample_out)
    else $error("sample pulse without frame select fall");

  count_restart_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_fall |=> state.edges == ASPM_CNT_ZERO)
    else $error("edge counter not restarted at frame select fall");

  mode_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
    !frame_rise && !(state.active && !frame_n && sclk_fall)
    |=> $stable(power_mode_out))
    else $error("power mode changed outside a decision point");

  idle_release_a: assert property (@(posedge clock_in) disable iff (rst_in)
    frame_n |=> !serial_result_oe_out)
    else $error("output driven while frame select high");

  full_wake_a: assert property (@(posedge clock_in) disable iff (rst_in)
    state.active && !frame_n && sclk_fall && state.edges == 5'h0F
    |=> power_mode_out == ASPM_NORMAL)
    else $error("device not powered after full frame");
endmodule // aspm_ctrl
`default_nettype wire

/* testbench/aspm_host.sv */
// Purpose: host serial master model, frame select and serial clock
// Assumes: 160 ns serial clock, bench clock 10 ns
// Notes: serial clock idles high and stands still between frames
`default_nettype none
module aspm_host #(
  parameter int QUIET = 100
) (
  input  wire logic clock_in,
  input  wire logic sdo_in,
  input  wire logic oe_in,
  output var  logic frame_sel_n_out,
  output var  logic serial_clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frame_sel_n_out = 1'b1;
    serial_clk_out  = 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge clock_in);
  endtask
  task automatic frame(input int n, output logic [15:0] w);
    w = 16'hFFFF;
    frame_sel_n_out = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      w[15-i] = oe_in ? sdo_in : 1'bx;
      serial_clk_out = 1'b0;
      half();
      serial_clk_out = 1'b1;
      half();
    end
    frame_sel_n_out = 1'b1;
    repeat (QUIET) @(negedge clock_in);
  endtask
endmodule // aspm_host
`default_nettype wire

/* testbench/adc_serial_power_mode_ctrl_tb.sv */
// Purpose: self-checking bench for the serial readout and power modes
// Assumes: host model drives frame select and serial clock
// Notes: mode and release checked after each frame
`default_nettype none
module adc_serial_power_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aspm_pkg::*;
  logic        clock_in;
  logic        rst_in;
  logic        fs_n;
  logic        sclk;
  logic        sdo;
  logic        oe;
  logic        sample;
  logic [1:0]  mode;
  logic [11:0] res;
  logic [15:0] w;
  int          mismatches = 0;
  int          n_tests = 0;
  int          n_samp = 0;
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (sample === 1'b1) n_samp <= n_samp + 1;
  end
  aspm_ctrl i_dut (.clock_in(clock_in), .rst_in(rst_in), .frame_sel_n_in(fs_n),
    .serial_clk_in(sclk), .conv_result_in(res), .serial_result_out(sdo),
    .serial_result_oe_out(oe), .power_mode_out(mode), .sample_out(sample));
  aspm_host i_host (.clock_in(clock_in), .sdo_in(sdo), .oe_in(oe),
    .frame_sel_n_out(fs_n), .serial_clk_out(sclk));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input int n, input logic [11:0] r, input aspm_mode_e md,
                     input string m);
    int s0;
    s0 = n_samp;
    res = r;
    i_host.frame(n, w);
    chk({14'h0000, mode}, {14'h0000, md}, {m, " mode"});
    chk({15'h0000, oe}, 16'h0000, {m, " release"});
    chk(16'(n_samp - s0), 16'h0001, {m, " sample"});
    $display("test %s done", m);
  endtask
  task automatic t_full();
    run(16, 12'hA5C, ASPM_NORMAL, "full");
    chk(w, {2'b00, 12'hA5C, 2'b00}, "full word");
  endtask
  task automatic t_abort();
    run(14, 12'hC35, ASPM_NORMAL, "abort14");
    chk(w[15:2], {2'b00, 12'hC35}, "abort14 word");
  endtask
  task automatic t_modes();
    run(1, 12'h001, ASPM_NORMAL, "glitch");
    run(2, 12'h002, ASPM_PARTIAL, "partial2");
    run(9, 12'h003, ASPM_FULL, "full9");
    run(10, 12'h004, ASPM_NORMAL, "wake10");
    run(9, 12'h005, ASPM_PARTIAL, "partial9");
    run(5, 12'h006, ASPM_FULL, "full5");
    run(16, 12'h007, ASPM_NORMAL, "wake16");
    t_full();
  endtask
  task automatic t_reset();
    run(2, 12'h008, ASPM_PARTIAL, "partial_pre_reset");
    rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk({13'h0000, oe, mode}, 16'h0000, "mid reset");
    run(16, 12'h3C9, ASPM_NORMAL, "after_reset");
    chk(w, {2'b00, 12'h3C9, 2'b00}, "after_reset word");
    $display("test mid_reset done");
  endtask
  initial begin
    rst_in = 1'b1;
    res = 12'h000;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk({13'h0000, oe, mode}, 16'h0000, "reset");
    t_full();
    t_abort();
    t_modes();
    t_reset();
    give_verdict();
  end
endmodule // adc_serial_power_mode_ctrl_tb
`default_nettype wire
